// ===== verilog/qrb_pkg.sv
// package: constants and carrier types for the burst-of-four sram port logic
//
// Contract
// - write starts on write select low, read high
// - read starts on read select low; 2.5-cycle latency
// - power-up deselected, outputs tristated, nop ignores data
// - clocks stopped: all outputs hold previous state
// - select that started previous op is ignored
// - second back-to-back read or write is ignored
// - data in and out on both clock rises
// - burst touches address, plus one, two, three
// - narrow width: two byte selects mask lanes
// - wide width: four byte selects mask lanes
// - byte mask sampled per individual data word
// - both selected: arbitrate on previous started operation
// - port selects sampled on positive clock only
`default_nettype none

package qrb_pkg;

	// =========================================================
	// widths
	localparam int unsigned DATA_W  = 36;
	localparam int unsigned LANE_W  = 9;
	localparam int unsigned LANES   = DATA_W / LANE_W;
	localparam int unsigned ADDR_W  = 8;
	localparam int unsigned WORDS   = 1 << ADDR_W;

	// =========================================================
	// half-step schedule, counted in clock-pair rises from start
	localparam int unsigned WR_FIRST = 2;
	localparam int unsigned WR_LAST  = 5;
	localparam int unsigned RD_FIRST = 5;
	localparam int unsigned RD_LAST  = 8;
	localparam int unsigned WR_DEPTH = WR_LAST;
	localparam int unsigned RD_DEPTH = RD_LAST;

	// =========================================================
	// reset values
	localparam logic [DATA_W-1:0] Q_RESET  = 36'h0_0000_0000;
	localparam logic              OE_OFF_N = 1'b1;

	// =========================================================
	// types
	typedef enum logic [1:0] {
		QRB_LAST_NONE  = 2'b00,
		QRB_LAST_READ  = 2'b01,
		QRB_LAST_WRITE = 2'b10
	} qrb_last_e;

	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] addr;
	} qrb_slot_s;

	typedef struct packed {
		logic              oe_n;
		logic [DATA_W-1:0] data;
	} qrb_q_s;

endpackage : qrb_pkg

`default_nettype wire

// ===== verilog/qrb_edge.sv
// rising-edge detection of the sampled clock-pair inputs
`default_nettype none

module qrb_edge (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// sampled levels
	input  wire logic [1:0] level,
	// one-cycle rise pulses
	output logic      [1:0] rise
);
	import qrb_pkg::*;

	logic [1:0] prev_q;

	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_bit
			// parked high at reset so no false rise
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					prev_q[i] <= 1'b1;
				end else begin
					prev_q[i] <= level[i];
				end
			end
			assign rise[i] = level[i] & ~prev_q[i];
		end
	endgenerate

endmodule : qrb_edge

`default_nettype wire

// ===== verilog/qrb_mem.sv
// storage array with per-lane write enables
`default_nettype none

module qrb_mem (
	// clock
	input  wire logic                          sys_clk,
	// write side
	input  wire logic                          wr_en,
	input  wire logic [qrb_pkg::ADDR_W-1:0]    wr_addr,
	input  wire logic [qrb_pkg::DATA_W-1:0]    wr_data,
	input  wire logic [qrb_pkg::LANES-1:0]     wr_lane_n,
	// read side
	input  wire logic [qrb_pkg::ADDR_W-1:0]    rd_addr,
	output logic      [qrb_pkg::DATA_W-1:0]    rd_data
);
	import qrb_pkg::*;

	genvar b;
	generate
		for (b = 0; b < LANES; b++) begin : g_lane
			// one array per lane, so each has a single writing process
			logic [LANE_W-1:0] lane_q [WORDS];

			// low select writes this lane, high leaves it
			always_ff @(posedge sys_clk) begin
				if (wr_en && !wr_lane_n[b]) begin
					lane_q[wr_addr] <= wr_data[b*LANE_W +: LANE_W];
				end
			end

			assign rd_data[b*LANE_W +: LANE_W] = lane_q[rd_addr];
		end
	endgenerate

endmodule : qrb_mem

`default_nettype wire

// ===== verilog/qrb_sram_ports.sv
// port logic of the burst-of-four sram: start, arbitration, burst data paths
`default_nettype none

module qrb_sram_ports (
	// clock and reset
	input  wire logic                         sys_clk,
	input  wire logic                         rst_n,
	// clock pair from the controller, sampled as levels
	input  wire logic                         k_clk,
	input  wire logic                         k_clk_n,
	// port selects and address
	input  wire logic                         read_port_select_n,
	input  wire logic                         write_port_select_n,
	input  wire logic [qrb_pkg::ADDR_W-1:0]   addr,
	// write data port
	input  wire logic [qrb_pkg::DATA_W-1:0]   d_data,
	input  wire logic [qrb_pkg::LANES-1:0]    byte_write_select_n,
	// read data port
	output logic      [qrb_pkg::DATA_W-1:0]   q_data,
	output logic                              q_oe_n
);
	import qrb_pkg::*;

	// =========================================================
	// clock-pair edges
	logic [1:0] rise;
	logic       k_rise;
	logic       kn_rise;
	logic       any_rise;

	qrb_edge u_edge (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.level   ({k_clk_n, k_clk}),
		.rise    (rise)
	);

	assign k_rise   = rise[0];
	assign kn_rise  = rise[1];
	// data moves on both rises, nothing moves without one
	assign any_rise = k_rise | kn_rise;

	// =========================================================
	// start and arbitration
	qrb_last_e last_q;
	logic      rd_elig;
	logic      wr_elig;
	logic      rd_start;
	logic      wr_start;

	// a select that started the previous op is ignored
	assign rd_elig  = !read_port_select_n && (last_q != QRB_LAST_READ);
	assign wr_elig  = !write_port_select_n && (last_q != QRB_LAST_WRITE);
	// selects only looked at on the positive rise
	// read wins when both eligible; after a read only write is eligible
	assign rd_start = k_rise && rd_elig;
	assign wr_start = k_rise && wr_elig && !rd_elig;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			last_q <= QRB_LAST_NONE;
		end else if (k_rise) begin
			if (rd_start) begin
				last_q <= QRB_LAST_READ;
			end else if (wr_start) begin
				last_q <= QRB_LAST_WRITE;
			end else begin
				last_q <= QRB_LAST_NONE;
			end
		end
	end

	// =========================================================
	// burst schedule pipelines, one stage per clock-pair rise
	qrb_slot_s wr_pipe_q [WR_DEPTH];
	qrb_slot_s rd_pipe_q [RD_DEPTH];

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < WR_DEPTH; i++) begin
				wr_pipe_q[i] <= '0;
			end
		end else if (any_rise) begin
			wr_pipe_q[0] <= '{valid: wr_start, addr: addr};
			for (int i = 1; i < WR_DEPTH; i++) begin
				wr_pipe_q[i] <= wr_pipe_q[i-1];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < RD_DEPTH; i++) begin
				rd_pipe_q[i] <= '0;
			end
		end else if (any_rise) begin
			rd_pipe_q[0] <= '{valid: rd_start, addr: addr};
			for (int i = 1; i < RD_DEPTH; i++) begin
				rd_pipe_q[i] <= rd_pipe_q[i-1];
			end
		end
	end

	// =========================================================
	// word selection within a burst
	logic              wr_word;
	logic [ADDR_W-1:0] wr_addr;
	logic              rd_word;
	logic [ADDR_W-1:0] rd_addr;

	always_comb begin
		wr_word = 1'b0;
		wr_addr = '0;
		// the stage reaching WR_FIRST..WR_LAST on this rise carries a word
		for (int i = WR_FIRST - 1; i < WR_LAST; i++) begin
			if (wr_pipe_q[i].valid) begin
				wr_word = 1'b1;
				wr_addr = wr_pipe_q[i].addr + ADDR_W'(i - (WR_FIRST - 1));
			end
		end
	end

	always_comb begin
		rd_word = 1'b0;
		rd_addr = '0;
		for (int i = RD_FIRST - 1; i < RD_LAST; i++) begin
			if (rd_pipe_q[i].valid) begin
				rd_word = 1'b1;
				rd_addr = rd_pipe_q[i].addr + ADDR_W'(i - (RD_FIRST - 1));
			end
		end
	end

	// =========================================================
	// storage; each word lands as taken so reads see newest data
	logic [DATA_W-1:0] mem_rd;

	qrb_mem u_mem (
		.sys_clk   (sys_clk),
		.wr_en     (any_rise && wr_word),
		.wr_addr   (wr_addr),
		.wr_data   (d_data),
		.wr_lane_n (byte_write_select_n),
		.rd_addr   (rd_addr),
		.rd_data   (mem_rd)
	);

	// =========================================================
	// read data output register
	qrb_q_s q_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			q_q <= '{oe_n: OE_OFF_N, data: Q_RESET};
		end else if (any_rise) begin
			if (rd_word) begin
				q_q <= '{oe_n: 1'b0, data: mem_rd};
			end else if (kn_rise) begin
				// release after the negative rise that follows the last word
				q_q.oe_n <= OE_OFF_N;
			end
		end
	end

	assign q_data = q_q.data;
	assign q_oe_n = q_q.oe_n;

endmodule : qrb_sram_ports

`default_nettype wire

// ===== tb/qrb_ctrl_model.sv
// partner: controller model making the clock pair
`default_nettype none

module qrb_ctrl_model (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// clock pair
	input  wire logic       run,
	output logic            k_clk,
	output logic            k_clk_n,
	output logic      [1:0] phase
);
	timeunit 1ns;
	timeprecision 1ns;
	import qrb_pkg::*;
	// =========================================================
	// half steps: k rises entering phase 0, k_n entering phase 2
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			phase   <= 2'h3;
			k_clk   <= 1'b0;
			k_clk_n <= 1'b1;
		end else if (run) begin
			phase   <= phase + 2'h1;
			k_clk   <= phase[0] ~^ phase[1];
			k_clk_n <= phase[0] ^ phase[1];
		end
	end
endmodule : qrb_ctrl_model

`default_nettype wire

// ===== tb/qrb_sram_ports_checker.sv
// checker: port assertions for the burst-of-four sram ports
`default_nettype none

module qrb_sram_ports_checker (
	// clock and reset
	input  wire logic                       sys_clk,
	input  wire logic                       rst_n,
	// clock pair and read port
	input  wire logic                       k_clk,
	input  wire logic                       k_clk_n,
	input  wire logic [qrb_pkg::DATA_W-1:0] q_data,
	input  wire logic                       q_oe_n
);
	timeunit 1ns;
	timeprecision 1ns;
	import qrb_pkg::*;
	// =========================================================
	// rise helpers
	logic      k_q;
	logic      kn_q;
	wire logic k_rise  = k_clk & ~k_q;
	wire logic kn_rise = k_clk_n & ~kn_q;
	always_ff @(posedge sys_clk) begin
		k_q  <= k_clk;
		kn_q <= k_clk_n;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_q_rise; $changed(q_data) |-> $past(k_rise | kn_rise); endproperty
	a_q_rise: assert property (p_q_rise) else $error("q moved no rise");
	property p_on; $fell(q_oe_n) |-> $past(kn_rise); endproperty
	a_on: assert property (p_on) else $error("enable off k_n");
	property p_off; $rose(q_oe_n) |-> $past(kn_rise); endproperty
	a_off: assert property (p_off) else $error("release off k_n");
	property p_len; $fell(q_oe_n) |-> (!q_oe_n) [*4]; endproperty
	a_len: assert property (p_len) else $error("short burst");
	property p_rst_oe; $rose(rst_n) |-> q_oe_n [*6]; endproperty
	a_rst_oe: assert property (p_rst_oe) else $error("driven at reset");
	property p_rst_q; $rose(rst_n) |-> q_data == Q_RESET; endproperty
	a_rst_q: assert property (p_rst_q) else $error("q reset value");
	property p_stop; ($stable(k_clk) && $stable(k_clk_n)) [*3] |-> $stable({q_oe_n, q_data}); endproperty
	a_stop: assert property (p_stop) else $error("moved while stopped");
	property p_oe_rise; $changed(q_oe_n) |-> $past(k_rise | kn_rise); endproperty
	a_oe_rise: assert property (p_oe_rise) else $error("oe moved no rise");
endmodule : qrb_sram_ports_checker

bind qrb_sram_ports qrb_sram_ports_checker qrb_sram_ports_checker_inst (.sys_clk(sys_clk),
	.rst_n(rst_n), .k_clk(k_clk), .k_clk_n(k_clk_n), .q_data(q_data), .q_oe_n(q_oe_n));

`default_nettype wire

// ===== tb/qrb_sram_ports_tb.sv
// testbench: burst-of-four sram ports with a clocking controller model
`default_nettype none

module qrb_sram_ports_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import qrb_pkg::*;
	// =========================================================
	// stimulus and hookup
	logic              sys_clk  = 1'b0;
	logic              rst_n    = 1'b0;
	logic              run      = 1'b1;
	logic              rd_sel_n = 1'b1;
	logic              wr_sel_n = 1'b1;
	logic [ADDR_W-1:0] adr      = '0;
	logic [DATA_W-1:0] dat      = '0;
	logic [LANES-1:0]  lane_n   = '0;
	logic              k_clk, k_clk_n, q_oe_n;
	logic [1:0]        phase;
	logic [DATA_W-1:0] q_data;
	int                error_cnt = 0, n_compared = 0, cyc = 0;
	always #50 sys_clk = ~sys_clk;
	qrb_ctrl_model qrb_ctrl_model_inst (.sys_clk(sys_clk), .rst_n(rst_n), .run(run),
		.k_clk(k_clk), .k_clk_n(k_clk_n), .phase(phase));
	qrb_sram_ports qrb_sram_ports_inst (.sys_clk(sys_clk), .rst_n(rst_n), .k_clk(k_clk),
		.k_clk_n(k_clk_n), .read_port_select_n(rd_sel_n), .write_port_select_n(wr_sel_n),
		.addr(adr), .d_data(dat), .byte_write_select_n(lane_n), .q_data(q_data), .q_oe_n(q_oe_n));
	function automatic logic [DATA_W-1:0] dw(input int i);
		return DATA_W'(i + 1) * 36'h0_0804_0201;
	endfunction : dw
	function automatic logic [DATA_W-1:0] mrg(input logic [DATA_W-1:0] o, n, input logic [3:0] m);
		for (int b = 0; b < LANES; b++) if (!m[b]) o[LANE_W*b+:LANE_W] = n[LANE_W*b+:LANE_W];
		return o;
	endfunction : mrg
	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	task chk(input logic oe, input logic [DATA_W-1:0] q, input logic cq);
		n_compared++;
		if (q_oe_n !== oe || (cq && q_data !== q)) begin
			error_cnt++;
			$display("MISMATCH %0t q %h oe %b", $time, q_data, q_oe_n);
		end
	endtask : chk
	// one half step: drive with the next rise, return once the prior step's word shows
	task hs(input logic r, w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic [LANES-1:0] m);
		while (!phase[0]) @(negedge sys_clk);
		@(posedge sys_clk);
		{rd_sel_n, wr_sel_n, adr, dat, lane_n} <= {r, w, a, d, m};
		@(negedge sys_clk);
	endtask : hs
	task t_reset;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(negedge sys_clk);
		chk(1'b1, Q_RESET, 1'b1);
	endtask : t_reset
	// even step count, so the next scenario starts on a positive rise
	task t_write_read;
		logic [LANES-1:0] mk;
		for (int i = 0; i < 18; i++) begin
			mk = (i inside {[6:9]}) ? LANES'(16'h0F7E >> (4 * (i - 6))) : 4'h0;
			hs(i != 6, !(i inside {0, 2, 4}), 8'hFE, dw(i - 2), mk);
			mk = LANES'(16'h0F7E >> (4 * (i - 12)));
			if (i inside {[12:15]}) chk(1'b0, mrg(dw(i - 12), dw(i - 8), mk), 1'b1);
			else if (i == 11 || i > 15) chk(1'b1, '0, 1'b0);
		end
	endtask : t_write_read
	task t_arbitrate;
		logic [LANES-1:0] mk;
		for (int i = 0; i < 15; i++) begin
			hs(i > 4, !(i inside {0, 2, 4}), (i == 0) ? 8'hFE : 8'h10, dw(i + 4), '0);
			mk = LANES'(16'h0F7E >> (4 * (i - 6)));
			if (i inside {[6:9]}) chk(1'b0, mrg(dw(i - 6), dw(i - 2), mk), 1'b1);
			else if (i inside {[10:13]}) chk(1'b0, dw(i - 2), 1'b1);
			else if (i == 14) chk(1'b1, '0, 1'b0);
			if (i == 7) begin
				@(posedge sys_clk) run <= 1'b0;
				repeat (20) @(posedge sys_clk);
				run <= 1'b1;
				@(negedge sys_clk);
				chk(1'b0, mrg(dw(2), dw(6), 4'hF), 1'b1);
			end
		end
	endtask : t_arbitrate
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			error_cnt++;
			print_verdict;
		end
	end
	initial begin
		t_reset;
		t_write_read;
		t_arbitrate;
		print_verdict;
	end
endmodule : qrb_sram_ports_tb

`default_nettype wire
